// >>> shared/sss_pkg.sv
// Shared constants for the subtract, swap and skip execution block
package sss_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned OPC_W    = 3;
  localparam int unsigned BITSEL_W = 3;

  // ********************************************************
  // Operation codes on i_opcode
  // ********************************************************
  localparam logic [OPC_W-1:0] OP_NONE                        = 3'h0;
  localparam logic [OPC_W-1:0] OP_MINUS_TO_MEMORY             = 3'h1;
  localparam logic [OPC_W-1:0] OP_MINUS_IMMEDIATE             = 3'h2;
  localparam logic [OPC_W-1:0] OP_NIBBLE_EXCHANGE             = 3'h3;
  localparam logic [OPC_W-1:0] OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 3'h4;
  localparam logic [OPC_W-1:0] OP_SKIP_ON_NULL                = 3'h5;
  localparam logic [OPC_W-1:0] OP_SKIP_ON_NULL_LOAD           = 3'h6;
  localparam logic [OPC_W-1:0] OP_SKIP_ON_BIT_CLEAR           = 3'h7;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic              FLAG_RST  = 1'b0;

  // ********************************************************
  // Sequencer states, one-hot
  // ********************************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } sss_state_e;

endpackage

// >>> src/sss_exec.sv
// Execution unit for subtract, nibble exchange and zero-skip instructions
`timescale 1ns/1ps
// Contract
// - Minus-to-memory writes accumulator minus memory byte to memory, accumulator kept.
// - Carry cleared on negative difference, set on zero or positive difference.
// - Both subtract forms update overflow, zero, nibble, carry, sign, chained flags.
// - Subtract-immediate puts accumulator minus literal into the accumulator.
// - In-place nibble exchange swaps memory byte halves, flags untouched.
// - Exchange-to-accumulator loads swapped operand into accumulator, memory and flags kept.
// - Byte skip-on-null skips next instruction when byte is zero, changes nothing.
// - A taken skip inserts one dummy cycle, two instruction cycles total.
// - Skip-on-null-load copies byte to accumulator, skips if zero, flags kept.
// - Bit skip tests selected bit, skips when clear, flags kept.
// - Untaken skip continues with the following instruction normally.
module sss_exec #(
  parameter int unsigned W = sss_pkg::DATA_W
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_op_valid,
  input  wire logic [sss_pkg::OPC_W-1:0]     i_opcode,
  input  wire logic [W-1:0]                  i_operand,
  input  wire logic [W-1:0]                  i_literal,
  input  wire logic [sss_pkg::BITSEL_W-1:0]  i_bit_sel,
  input  wire logic                          i_acc_wr,
  input  wire logic [W-1:0]                  i_acc_wdata,
  output logic      [W-1:0]                  o_acc,
  output logic                               o_mem_wr,
  output logic      [W-1:0]                  o_mem_wdata,
  output logic                               o_dummy_cycle,
  output logic                               o_op_done,
  output logic                               o_signed_range_exceeded_flag,
  output logic                               o_zero_flag,
  output logic                               o_nibble_borrow_flag,
  output logic                               o_carry_flag,
  output logic                               o_signed_result_flag,
  output logic                               o_chained_null_flag
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [W-1:0] nib_exchange(input logic [W-1:0] b);
    nib_exchange = {b[sss_pkg::NIB_W-1:0], b[W-1:sss_pkg::NIB_W]};
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  sss_pkg::sss_state_e state;
  sss_pkg::sss_state_e next_state;
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic         mem_wr;
  logic         next_mem_wr;
  logic [W-1:0] mem_wdata;
  logic [W-1:0] next_mem_wdata;
  logic         op_done;
  logic         next_op_done;
  logic         dummy;
  logic         next_dummy;
  logic         f_range;
  logic         f_z;
  logic         f_nib;
  logic         f_c;
  logic         f_sign;
  logic         f_chain;
  logic         next_f_range;
  logic         next_f_z;
  logic         next_f_nib;
  logic         next_f_c;
  logic         next_f_sign;
  logic         next_f_chain;

  // ********************************************************
  // Datapath helpers
  // ********************************************************
  logic [W-1:0] sub_rhs;
  logic [W-1:0] diff;
  logic         d_range;
  logic         d_z;
  logic         d_nib;
  logic         d_c;
  logic         d_sign;
  logic         d_chain;
  logic         is_skip_op;
  logic         skip_cond;
  logic         run_op;

  assign sub_rhs = (i_opcode == sss_pkg::OP_MINUS_IMMEDIATE) ? i_literal : i_operand;
  assign run_op  = i_op_valid && (state == sss_pkg::ST_RUN);

  sss_sub_flags #(
    .W (W)
  ) u_sub (
    .i_minuend               (acc),
    .i_subtrahend            (sub_rhs),
    .o_diff                  (diff),
    .o_signed_range_exceeded (d_range),
    .o_zero                  (d_z),
    .o_nibble_borrow         (d_nib),
    .o_carry                 (d_c),
    .o_signed_result         (d_sign),
    .o_chained_null          (d_chain)
  );

  sss_skip_test #(
    .W (W)
  ) u_skip (
    .i_opcode     (i_opcode),
    .i_operand    (i_operand),
    .i_bit_sel    (i_bit_sel),
    .o_is_skip_op (is_skip_op),
    .o_skip       (skip_cond)
  );

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    next_state     = state;
    next_acc       = acc;
    next_mem_wr    = 1'b0;
    next_mem_wdata = mem_wdata;
    next_op_done   = 1'b0;
    next_f_range   = f_range;
    next_f_z       = f_z;
    next_f_nib     = f_nib;
    next_f_c       = f_c;
    next_f_sign    = f_sign;
    next_f_chain   = f_chain;
    // Outside loads of the accumulator lose to an executing subtract, exchange-to-accumulator or null-load op
    if (i_acc_wr) begin
      next_acc = i_acc_wdata;
    end
    case (state)
      sss_pkg::ST_RUN: begin
        if (i_op_valid) begin
          next_op_done = 1'b1;
          case (i_opcode)
            sss_pkg::OP_MINUS_TO_MEMORY: begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = diff;
              next_acc       = acc;
            end
            sss_pkg::OP_MINUS_IMMEDIATE: begin
              next_acc = diff;
            end
            sss_pkg::OP_NIBBLE_EXCHANGE: begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = nib_exchange(i_operand);
            end
            sss_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: begin
              next_acc = nib_exchange(i_operand);
            end
            sss_pkg::OP_SKIP_ON_NULL_LOAD: begin
              next_acc = i_operand;
            end
            default: begin
            end
          endcase
          if (i_opcode == sss_pkg::OP_MINUS_TO_MEMORY ||
              i_opcode == sss_pkg::OP_MINUS_IMMEDIATE) begin
            next_f_range = d_range;
            next_f_z     = d_z;
            next_f_nib   = d_nib;
            next_f_c     = d_c;
            next_f_sign  = d_sign;
            next_f_chain = d_chain;
          end
          // Taken skip: the next fetched slot becomes a dummy no-op
          if (is_skip_op && skip_cond) begin
            next_state = sss_pkg::ST_DUMMY;
          end
        end
      end
      sss_pkg::ST_DUMMY: begin
        // Whatever the sequencer presents here is discarded
        if (i_op_valid) begin
          next_state = sss_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = sss_pkg::ST_RUN;
      end
    endcase
    // Registered copy so the output leaves a flip-flop directly
    next_dummy = (next_state == sss_pkg::ST_DUMMY);
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= sss_pkg::ST_RUN;
      acc       <= sss_pkg::ACC_RST;
      mem_wr    <= 1'b0;
      mem_wdata <= sss_pkg::BYTE_ZERO;
      op_done   <= 1'b0;
      dummy     <= 1'b0;
      f_range   <= sss_pkg::FLAG_RST;
      f_z       <= sss_pkg::FLAG_RST;
      f_nib     <= sss_pkg::FLAG_RST;
      f_c       <= sss_pkg::FLAG_RST;
      f_sign    <= sss_pkg::FLAG_RST;
      f_chain   <= sss_pkg::FLAG_RST;
    end else begin
      state     <= next_state;
      acc       <= next_acc;
      mem_wr    <= next_mem_wr;
      mem_wdata <= next_mem_wdata;
      op_done   <= next_op_done;
      dummy     <= next_dummy;
      f_range   <= next_f_range;
      f_z       <= next_f_z;
      f_nib     <= next_f_nib;
      f_c       <= next_f_c;
      f_sign    <= next_f_sign;
      f_chain   <= next_f_chain;
    end
  end

  assign o_acc                        = acc;
  assign o_mem_wr                     = mem_wr;
  assign o_mem_wdata                  = mem_wdata;
  assign o_dummy_cycle                = dummy;
  assign o_op_done                    = op_done;
  assign o_signed_range_exceeded_flag = f_range;
  assign o_zero_flag                  = f_z;
  assign o_nibble_borrow_flag         = f_nib;
  assign o_carry_flag                 = f_c;
  assign o_signed_result_flag         = f_sign;
  assign o_chained_null_flag          = f_chain;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  logic sub_op;
  assign sub_op = run_op && (i_opcode == sss_pkg::OP_MINUS_TO_MEMORY ||
                             i_opcode == sss_pkg::OP_MINUS_IMMEDIATE);

  chk_mem_minus: assert property (
    run_op && i_opcode == sss_pkg::OP_MINUS_TO_MEMORY
    |=> o_mem_wr && o_mem_wdata == W'($past(acc) - $past(i_operand))
        && o_acc == $past(acc))
    else $error("minus to memory result wrong");

  chk_carry_sense: assert property (
    sub_op |=> o_carry_flag == ($past(acc) >= $past(sub_rhs)))
    else $error("carry does not match borrow");

  chk_zero_chain: assert property (
    sub_op |=> o_zero_flag == ($past(diff) == sss_pkg::BYTE_ZERO)
               && o_chained_null_flag == o_zero_flag)
    else $error("zero or chained zero flag wrong");

  chk_imm_minus: assert property (
    run_op && i_opcode == sss_pkg::OP_MINUS_IMMEDIATE
    |=> o_acc == W'($past(acc) - $past(i_literal)) && !o_mem_wr)
    else $error("immediate subtract result wrong");

  chk_swap_mem: assert property (
    run_op && i_opcode == sss_pkg::OP_NIBBLE_EXCHANGE
    |=> o_mem_wr && o_mem_wdata == nib_exchange($past(i_operand))
        && $stable(o_carry_flag) && $stable(o_zero_flag))
    else $error("nibble exchange to memory wrong");

  chk_swap_acc: assert property (
    run_op && i_opcode == sss_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR
    |=> !o_mem_wr && o_acc == nib_exchange($past(i_operand)) && $stable(o_carry_flag))
    else $error("nibble exchange to accumulator wrong");

  chk_null_skip: assert property (
    run_op && i_opcode == sss_pkg::OP_SKIP_ON_NULL && i_operand == sss_pkg::BYTE_ZERO
    |=> o_dummy_cycle && !o_mem_wr && $stable(o_zero_flag))
    else $error("skip on null not taken");

  chk_dummy_len: assert property (
    o_dummy_cycle && i_op_valid |=> !o_dummy_cycle && !o_op_done)
    else $error("dummy cycle not single");

  chk_load_skip: assert property (
    run_op && i_opcode == sss_pkg::OP_SKIP_ON_NULL_LOAD
    |=> o_acc == $past(i_operand)
        && o_dummy_cycle == ($past(i_operand) == sss_pkg::BYTE_ZERO))
    else $error("skip on null load wrong");

  chk_bit_skip: assert property (
    run_op && i_opcode == sss_pkg::OP_SKIP_ON_BIT_CLEAR
    |=> o_dummy_cycle == !$past(i_operand[i_bit_sel]) && $stable(o_carry_flag))
    else $error("bit skip decision wrong");

  chk_no_skip: assert property (
    run_op && !(is_skip_op && skip_cond) |=> !o_dummy_cycle)
    else $error("dummy cycle without taken skip");

  chk_one_cycle: assert property (
    run_op && is_skip_op && !skip_cond ##1 i_op_valid |-> !o_dummy_cycle ##1 o_op_done)
    else $error("untaken skip stalled");

endmodule

// >>> src/sss_skip_test.sv
// Skip condition evaluation for byte and bit zero tests
`timescale 1ns/1ps
module sss_skip_test #(
  parameter int unsigned W  = sss_pkg::DATA_W,
  parameter int unsigned SW = sss_pkg::BITSEL_W
) (
  input  wire logic [sss_pkg::OPC_W-1:0] i_opcode,
  input  wire logic [W-1:0]              i_operand,
  input  wire logic [SW-1:0]             i_bit_sel,
  output logic                           o_is_skip_op,
  output logic                           o_skip
);

  logic [W-1:0] sel_mask;

  // ********************************************************
  // One-hot bit select
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_mask
      assign sel_mask[g] = (i_bit_sel == SW'(g));
    end
  endgenerate

  always_comb begin
    o_is_skip_op = 1'b0;
    o_skip       = 1'b0;
    if (i_opcode == sss_pkg::OP_SKIP_ON_NULL ||
        i_opcode == sss_pkg::OP_SKIP_ON_NULL_LOAD) begin
      o_is_skip_op = 1'b1;
      o_skip       = (i_operand == sss_pkg::BYTE_ZERO);
    end else if (i_opcode == sss_pkg::OP_SKIP_ON_BIT_CLEAR) begin
      o_is_skip_op = 1'b1;
      o_skip       = ((i_operand & sel_mask) == sss_pkg::BYTE_ZERO);
    end
  end

endmodule

// >>> src/sss_sub_flags.sv
// Eight-bit subtractor with its status flag outputs
`timescale 1ns/1ps
module sss_sub_flags #(
  parameter int unsigned W = sss_pkg::DATA_W,
  parameter int unsigned N = sss_pkg::NIB_W
) (
  input  wire logic [W-1:0] i_minuend,
  input  wire logic [W-1:0] i_subtrahend,
  output logic      [W-1:0] o_diff,
  output logic              o_signed_range_exceeded,
  output logic              o_zero,
  output logic              o_nibble_borrow,
  output logic              o_carry,
  output logic              o_signed_result,
  output logic              o_chained_null
);

  logic [W:0] wide;

  always_comb begin
    wide   = {1'b0, i_minuend} - {1'b0, i_subtrahend};
    o_diff = wide[W-1:0];
    // Carry is the inverted borrow: 1 when no borrow out
    o_carry = ~wide[W];
    o_nibble_borrow = (i_minuend[N-1:0] >= i_subtrahend[N-1:0]);
    o_signed_range_exceeded = (i_minuend[W-1] != i_subtrahend[W-1])
                              && (o_diff[W-1] != i_minuend[W-1]);
    o_zero = (o_diff == {W{1'b0}});
    // True sign of the result, corrected for overflow
    o_signed_result = o_signed_range_exceeded ^ o_diff[W-1];
    // Plain subtraction is not chained, so it follows zero
    o_chained_null = o_zero;
  end

endmodule

// >>> testbench/tb_top.sv
// Self-checking testbench for the subtract, swap and skip execution block
`timescale 1ns/1ps
module tb_top;
  logic        i_sys_clk;
  logic        i_reset_n;
  logic        i_op_valid;
  logic [2:0]  i_opcode;
  logic [7:0]  i_operand;
  logic [7:0]  i_literal;
  logic [2:0]  i_bit_sel;
  logic        i_acc_wr;
  logic [7:0]  i_acc_wdata;
  logic [7:0]  o_acc;
  logic        o_mem_wr;
  logic [7:0]  o_mem_wdata;
  logic        o_dummy_cycle;
  logic        o_op_done;
  logic [5:0]  flags;
  logic [7:0]  acc_m;
  int          mismatches;
  int          cmp_count;

  sss_exec dut_u (
    .i_sys_clk                    (i_sys_clk),
    .i_reset_n                    (i_reset_n),
    .i_op_valid                   (i_op_valid),
    .i_opcode                     (i_opcode),
    .i_operand                    (i_operand),
    .i_literal                    (i_literal),
    .i_bit_sel                    (i_bit_sel),
    .i_acc_wr                     (i_acc_wr),
    .i_acc_wdata                  (i_acc_wdata),
    .o_acc                        (o_acc),
    .o_mem_wr                     (o_mem_wr),
    .o_mem_wdata                  (o_mem_wdata),
    .o_dummy_cycle                (o_dummy_cycle),
    .o_op_done                    (o_op_done),
    .o_signed_range_exceeded_flag (flags[5]),
    .o_zero_flag                  (flags[4]),
    .o_nibble_borrow_flag         (flags[3]),
    .o_carry_flag                 (flags[2]),
    .o_signed_result_flag         (flags[1]),
    .o_chained_null_flag          (flags[0])
  );

  // ********************************************************
  // Clock and helpers
  // ********************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Flag order: overflow, zero, nibble borrow, carry, sign, chained zero
  function automatic logic [5:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    logic       range_ex;
    d        = a - b;
    range_ex = (a[7] != b[7]) && (d[7] != a[7]);
    return {range_ex, d == 8'h00, a[3:0] >= b[3:0], a >= b, range_ex ^ d[7], d == 8'h00};
  endfunction

  task automatic set_acc(input logic [7:0] v);
    @(posedge i_sys_clk);
    i_acc_wr    <= 1'b1;
    i_acc_wdata <= v;
    @(posedge i_sys_clk);
    i_acc_wr <= 1'b0;
    #1;
    chk(o_acc === v, "accumulator load");
    acc_m = v;
  endtask

  // One instruction cycle, outputs sampled 1 ns after the taking edge
  task automatic exec(input logic [2:0] op, input logic [7:0] opd, input logic [7:0] lit,
                      input logic [2:0] bs);
    @(posedge i_sys_clk);
    i_op_valid <= 1'b1;
    i_opcode   <= op;
    i_operand  <= opd;
    i_literal  <= lit;
    i_bit_sel  <= bs;
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    #1;
    chk(o_op_done === 1'b1, "op done missing");
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_minus(input logic imm, input logic [7:0] a, input logic [7:0] b);
    set_acc(a);
    if (imm) begin
      exec(sss_pkg::OP_MINUS_IMMEDIATE, ~b, b, 3'h0);
      chk(o_acc === a - b, "immediate difference");
      chk(o_mem_wr === 1'b0, "immediate wrote memory");
      acc_m = a - b;
    end else begin
      exec(sss_pkg::OP_MINUS_TO_MEMORY, b, ~b, 3'h0);
      chk(o_mem_wr === 1'b1, "memory write missing");
      chk(o_mem_wdata === a - b, "memory difference");
      chk(o_acc === a, "accumulator changed");
    end
    chk(flags[2] === (a >= b), "carry sense");
    chk(flags === exp_flags(a, b), "subtract flags");
    @(posedge i_sys_clk);
    #1;
    chk(o_mem_wr === 1'b0 && o_op_done === 1'b0, "pulse too long");
  endtask

  task automatic t_swap();
    logic [5:0] f;
    f = flags;
    exec(sss_pkg::OP_NIBBLE_EXCHANGE, 8'h3c, 8'h00, 3'h0);
    chk(o_mem_wr === 1'b1 && o_mem_wdata === 8'hc3, "in-place swap");
    chk(flags === f && o_acc === acc_m, "in-place swap side effect");
    exec(sss_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'ha5, 8'h00, 3'h0);
    chk(o_acc === 8'h5a && o_mem_wr === 1'b0, "swap to accumulator");
    chk(flags === f, "swap to accumulator flags");
    acc_m = 8'h5a;
  endtask

  // Skip op followed at once by a subtract-immediate of one in the next slot
  task automatic t_skip(input logic [2:0] op, input logic [7:0] opd, input logic [2:0] bs,
                        input logic taken, input logic [7:0] acc_after);
    logic [5:0] f;
    f = flags;
    @(posedge i_sys_clk);
    i_op_valid <= 1'b1;
    i_opcode   <= op;
    i_operand  <= opd;
    i_bit_sel  <= bs;
    @(posedge i_sys_clk);
    i_opcode  <= sss_pkg::OP_MINUS_IMMEDIATE;
    i_literal <= 8'h01;
    #1;
    chk(o_op_done === 1'b1 && o_mem_wr === 1'b0, "skip op done");
    chk(o_dummy_cycle === taken, "dummy cycle entry");
    chk(flags === f && o_acc === acc_after, "skip side effect");
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    #1;
    chk(o_dummy_cycle === 1'b0, "dummy cycle stuck");
    chk(o_op_done === !taken, "following slot done");
    chk(!taken || flags === f, "dummy slot touched flags");
    acc_m = taken ? acc_after : acc_after - 8'h01;
    chk(o_acc === acc_m, "following slot result");
  endtask

  // ********************************************************
  // Closing
  // ********************************************************
  task automatic report_and_stop();
    $display("TB: compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_sys_clk);
    mismatches++;
    $display("[FAIL] %0t run limit reached", $time);
    report_and_stop();
  end

  initial begin
    mismatches  = 0;
    cmp_count   = 0;
    i_reset_n   = 1'b0;
    i_op_valid  = 1'b0;
    i_opcode    = sss_pkg::OP_NONE;
    i_operand   = 8'h00;
    i_literal   = 8'h00;
    i_bit_sel   = 3'h0;
    i_acc_wr    = 1'b0;
    i_acc_wdata = 8'h00;
    repeat (15) @(posedge i_sys_clk);
    #1;
    chk(o_acc === 8'h00 && flags === 6'h00 && o_dummy_cycle === 1'b0 && o_mem_wr === 1'b0
        && o_op_done === 1'b0 && o_mem_wdata === 8'h00, "reset values");
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_minus(1'b0, 8'h05, 8'h07);
    t_minus(1'b0, 8'h80, 8'h01);
    t_minus(1'b0, 8'h33, 8'h33);
    t_minus(1'b0, 8'h10, 8'h01);
    t_minus(1'b1, 8'h7f, 8'hff);
    t_minus(1'b1, 8'h07, 8'h05);
    t_minus(1'b1, 8'h42, 8'h42);
    t_swap();
    set_acc(8'h44);
    t_skip(sss_pkg::OP_SKIP_ON_NULL, 8'h00, 3'h0, 1'b1, acc_m);
    t_skip(sss_pkg::OP_SKIP_ON_NULL, 8'h10, 3'h0, 1'b0, acc_m);
    t_skip(sss_pkg::OP_SKIP_ON_NULL_LOAD, 8'h00, 3'h0, 1'b1, 8'h00);
    t_skip(sss_pkg::OP_SKIP_ON_NULL_LOAD, 8'h81, 3'h0, 1'b0, 8'h81);
    for (int i = 0; i < 8; i++) begin
      t_skip(sss_pkg::OP_SKIP_ON_BIT_CLEAR, ~(8'h01 << i), 3'(i), 1'b1, acc_m);
      t_skip(sss_pkg::OP_SKIP_ON_BIT_CLEAR, 8'h01 << i, 3'(i), 1'b0, acc_m);
    end
    report_and_stop();
  end
endmodule
